// ===== shared/ipf_pkg.sv
// ipf_pkg: constants and carrier types for the interrupt priority fields
// assumes: one 250 MHz core clock, plain register port with 16-bit data
package ipf_pkg;

    // ----------------------------------------------------------------
    // register map and widths
    // ----------------------------------------------------------------
    localparam int          REG_W    = 16;
    localparam int          ADDR_W   = 4;
    localparam int          PRIO_W   = 3;
    localparam int          NUM_SRC  = 4;
    localparam int          SRC_ID_W = 2;
    localparam logic [3:0]  PWM_GEN_IRQ_PRIORITY_OFS       = 4'h0;
    localparam logic [3:0]  CHANGE_NOTIFY_IRQ_PRIORITY_OFS = 4'h1;
    localparam logic [3:0]  ARB_STATUS_OFS                 = 4'h2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PWM_GEN4_PRIO_LSB      = 8;
    localparam int PWM_GEN3_PRIO_LSB      = 4;
    localparam int PWM_GEN2_PRIO_LSB      = 0;
    localparam int CHANGE_NOTIFY_PRIO_LSB = 12;
    localparam int STAT_REQ_BIT           = 0;
    localparam int STAT_LEVEL_LSB         = 4;
    localparam int STAT_ID_LSB            = 8;
    localparam int STAT_BAD_ACCESS_BIT    = 15;

    // ----------------------------------------------------------------
    // priority codes and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] PRIO_RESET    = 3'h4;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;
    localparam logic [2:0] PRIO_LOWEST   = 3'h1;
    localparam logic [2:0] PRIO_HIGHEST  = 3'h7;

    // source index order on the request and priority vectors
    localparam logic [1:0] SRC_PWM_GEN2      = 2'h0;
    localparam logic [1:0] SRC_PWM_GEN3      = 2'h1;
    localparam logic [1:0] SRC_PWM_GEN4      = 2'h2;
    localparam logic [1:0] SRC_CHANGE_NOTIFY = 2'h3;

    // one register access from software
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } ipf_bus_req_s;

    // the four priority fields as seen by arbitration
    typedef struct packed {
        logic [PRIO_W-1:0] change_notify_prio;
        logic [PRIO_W-1:0] pwm_gen4_prio;
        logic [PRIO_W-1:0] pwm_gen3_prio;
        logic [PRIO_W-1:0] pwm_gen2_prio;
    } ipf_prio_s;

endpackage

// ===== rtl/ipf_prio_field.sv
// ipf_prio_field: one 3-bit priority field taken from a register write
// assumes: write strobe and data on core_clk, clock enable freezes state
`timescale 1ns/1ns
`default_nettype none
module ipf_prio_field #(
    parameter int FIELD_LSB = 0
) (
    input  wire logic                     core_clk,  // core clock
    input  wire logic                     rst_n,     // sync reset, low
    input  wire logic                     clk_en,    // freezes state when low
    input  wire logic                     wr_en,     // write to owning register
    input  wire logic [ipf_pkg::REG_W-1:0] wdata,    // write data word
    output logic      [ipf_pkg::PRIO_W-1:0] prio_reg // stored priority code
);

    // field must sit inside the register word
    if (FIELD_LSB < 0 || FIELD_LSB + ipf_pkg::PRIO_W > ipf_pkg::REG_W) begin : g_bad_lsb
        $error("ipf_prio_field: field outside register word");
    end

    // field storage, reset to priority four
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prio_reg <= ipf_pkg::PRIO_RESET;
        end else if (clk_en && wr_en) begin
            prio_reg <= wdata[FIELD_LSB +: ipf_pkg::PRIO_W];
        end
    end

endmodule
`default_nettype wire

// ===== rtl/ipf_arbiter.sv
// ipf_arbiter: picks the highest-priority pending, enabled source
// assumes: pending flags come from logic on core_clk, no synchroniser
`timescale 1ns/1ns
`default_nettype none
module ipf_arbiter #(
    parameter int NUM_SRC = ipf_pkg::NUM_SRC
) (
    input  wire logic                               core_clk,  // core clock
    input  wire logic                               rst_n,     // sync reset, low
    input  wire logic                               clk_en,    // freezes state when low
    input  wire logic [NUM_SRC-1:0]                 pend,      // source pending flags
    input  wire logic [NUM_SRC*ipf_pkg::PRIO_W-1:0] prio,      // per-source priority codes
    output logic                                    req_reg,   // request to the core
    output logic      [ipf_pkg::PRIO_W-1:0]         level_reg, // level of winner
    output logic      [ipf_pkg::SRC_ID_W-1:0]       id_reg     // index of winner
);

    // id field must be able to name every source
    if (NUM_SRC < 1 || NUM_SRC > (1 << ipf_pkg::SRC_ID_W)) begin : g_bad_num
        $error("ipf_arbiter: source count does not fit id width");
    end

    logic [NUM_SRC-1:0]         elig;
    logic [ipf_pkg::PRIO_W-1:0] best_lvl;
    logic [ipf_pkg::SRC_ID_W-1:0] best_id;
    logic                       any_elig;

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_elig
        assign elig[i] = pend[i] && (prio[i*ipf_pkg::PRIO_W +: ipf_pkg::PRIO_W] != ipf_pkg::PRIO_DISABLED);
    end

    always_comb begin
        best_lvl = ipf_pkg::PRIO_DISABLED;
        best_id  = '0;
        any_elig = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i] && prio[i*ipf_pkg::PRIO_W +: ipf_pkg::PRIO_W] >= best_lvl) begin
                best_lvl = prio[i*ipf_pkg::PRIO_W +: ipf_pkg::PRIO_W];
                best_id  = ipf_pkg::SRC_ID_W'(i);
                any_elig = 1'b1;
            end
        end
    end

    // registered result for the core
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req_reg   <= 1'b0;
            level_reg <= ipf_pkg::PRIO_DISABLED;
            id_reg    <= '0;
        end else if (clk_en) begin
            req_reg   <= any_elig;
            level_reg <= best_lvl;
            id_reg    <= best_id;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/ipf_top.sv
// ipf_top: interrupt priority field registers with request arbitration
// assumes: software on the plain register port, sources on core_clk
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ipf_top #(
    parameter int DATA_W = 16
) (
    input  wire logic                          core_clk,    // core clock, 250 MHz
    input  wire logic                          rst_n,       // sync reset, low
    input  wire logic                          clk_en,      // freezes state when low
    input  wire ipf_pkg::ipf_bus_req_s         bus_req,     // strobes, address, data
    output logic      [DATA_W-1:0]             rd_data,     // read data, cycle after read
    input  wire logic [ipf_pkg::NUM_SRC-1:0]   src_pend,    // source pending flags
    output ipf_pkg::ipf_prio_s                 prio_fields, // field values to arbitration
    output logic                               irq_req,     // interrupt request level
    output logic      [ipf_pkg::PRIO_W-1:0]    irq_level,   // level of the request
    output logic      [ipf_pkg::SRC_ID_W-1:0]  irq_src_id   // source of the request
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------

    // the map is built for 16-bit words only
    if (DATA_W != ipf_pkg::REG_W) begin : g_bad_width
        $error("ipf_top: data width must equal register width");
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    logic hit_pwm;
    logic hit_cn;
    logic hit_stat;
    logic hit_any;
    logic wr_pwm;
    logic wr_cn;
    logic wr_stat;

    // one-hot selects for the three words
    assign hit_pwm  = (bus_req.addr == ipf_pkg::PWM_GEN_IRQ_PRIORITY_OFS);
    assign hit_cn   = (bus_req.addr == ipf_pkg::CHANGE_NOTIFY_IRQ_PRIORITY_OFS);
    assign hit_stat = (bus_req.addr == ipf_pkg::ARB_STATUS_OFS);
    assign hit_any  = hit_pwm || hit_cn || hit_stat;

    // write qualifiers per register
    assign wr_pwm  = bus_req.wr && hit_pwm;
    assign wr_cn   = bus_req.wr && hit_cn;
    assign wr_stat = bus_req.wr && hit_stat;

    // ----------------------------------------------------------------
    // priority field storage
    // ----------------------------------------------------------------

    logic [ipf_pkg::PRIO_W-1:0] gen4_q;
    logic [ipf_pkg::PRIO_W-1:0] gen3_q;
    logic [ipf_pkg::PRIO_W-1:0] gen2_q;
    logic [ipf_pkg::PRIO_W-1:0] cn_q;

    ipf_prio_field #(
        .FIELD_LSB (ipf_pkg::PWM_GEN4_PRIO_LSB)
    ) u_gen4 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .wr_en    (wr_pwm),
        .wdata    (bus_req.wdata),
        .prio_reg (gen4_q)
    );

    ipf_prio_field #(
        .FIELD_LSB (ipf_pkg::PWM_GEN3_PRIO_LSB)
    ) u_gen3 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .wr_en    (wr_pwm),
        .wdata    (bus_req.wdata),
        .prio_reg (gen3_q)
    );

    ipf_prio_field #(
        .FIELD_LSB (ipf_pkg::PWM_GEN2_PRIO_LSB)
    ) u_gen2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .wr_en    (wr_pwm),
        .wdata    (bus_req.wdata),
        .prio_reg (gen2_q)
    );

    ipf_prio_field #(
        .FIELD_LSB (ipf_pkg::CHANGE_NOTIFY_PRIO_LSB)
    ) u_cn (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .wr_en    (wr_cn),
        .wdata    (bus_req.wdata),
        .prio_reg (cn_q)
    );

    // ----------------------------------------------------------------
    // field outputs to arbitration
    // ----------------------------------------------------------------

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prio_fields.change_notify_prio <= ipf_pkg::PRIO_RESET;
            prio_fields.pwm_gen4_prio      <= ipf_pkg::PRIO_RESET;
            prio_fields.pwm_gen3_prio      <= ipf_pkg::PRIO_RESET;
            prio_fields.pwm_gen2_prio      <= ipf_pkg::PRIO_RESET;
        end else if (clk_en) begin
            prio_fields.change_notify_prio <= cn_q;
            prio_fields.pwm_gen4_prio      <= gen4_q;
            prio_fields.pwm_gen3_prio      <= gen3_q;
            prio_fields.pwm_gen2_prio      <= gen2_q;
        end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------

    logic [ipf_pkg::NUM_SRC*ipf_pkg::PRIO_W-1:0] prio_vec;

    // source order: gen2, gen3, gen4, change-notify
    assign prio_vec = {cn_q, gen4_q, gen3_q, gen2_q};

    ipf_arbiter #(
        .NUM_SRC (ipf_pkg::NUM_SRC)
    ) u_arb (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .pend      (src_pend),
        .prio      (prio_vec),
        .req_reg   (irq_req),
        .level_reg (irq_level),
        .id_reg    (irq_src_id)
    );

    // ----------------------------------------------------------------
    // bad access flag
    // ----------------------------------------------------------------

    logic bad_access_reg;
    logic bad_access_next;
    logic bad_set;
    logic bad_clr;

    // access to an unmapped word
    assign bad_set = (bus_req.wr || bus_req.rd) && !hit_any;
    // write one to the status flag bit clears it
    assign bad_clr = wr_stat && bus_req.wdata[ipf_pkg::STAT_BAD_ACCESS_BIT];

    // set wins over a clear in the same cycle
    always_comb begin
        bad_access_next = bad_access_reg;
        if (bad_clr) begin
            bad_access_next = 1'b0;
        end
        if (bad_set) begin
            bad_access_next = 1'b1;
        end
    end

    // sticky flag storage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bad_access_reg <= 1'b0;
        end else if (clk_en) begin
            bad_access_reg <= bad_access_next;
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------

    logic [DATA_W-1:0] pwm_word;
    logic [DATA_W-1:0] cn_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        pwm_word = '0;
        pwm_word[ipf_pkg::PWM_GEN4_PRIO_LSB +: ipf_pkg::PRIO_W] = gen4_q;
        pwm_word[ipf_pkg::PWM_GEN3_PRIO_LSB +: ipf_pkg::PRIO_W] = gen3_q;
        pwm_word[ipf_pkg::PWM_GEN2_PRIO_LSB +: ipf_pkg::PRIO_W] = gen2_q;
    end

    // only bits 14 to 12 live
    always_comb begin
        cn_word = '0;
        cn_word[ipf_pkg::CHANGE_NOTIFY_PRIO_LSB +: ipf_pkg::PRIO_W] = cn_q;
    end

    // arbitration state for software
    always_comb begin
        stat_word = '0;
        stat_word[ipf_pkg::STAT_REQ_BIT] = irq_req;
        stat_word[ipf_pkg::STAT_LEVEL_LSB +: ipf_pkg::PRIO_W] = irq_level;
        stat_word[ipf_pkg::STAT_ID_LSB +: ipf_pkg::SRC_ID_W] = irq_src_id;
        stat_word[ipf_pkg::STAT_BAD_ACCESS_BIT] = bad_access_reg;
    end

    // word select, unmapped reads give zero
    always_comb begin
        rd_mux = '0;
        if (hit_pwm) begin
            rd_mux = pwm_word;
        end else if (hit_cn) begin
            rd_mux = cn_word;
        end else if (hit_stat) begin
            rd_mux = stat_word;
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (clk_en) begin
            rd_data <= bus_req.rd ? rd_mux : '0;
        end
    end

endmodule
`default_nettype wire

// ===== dv/ipf_monitor.sv
// ipf_monitor: assertions on the priority field block ports
// assumes: bound to ipf_top, one core_clk domain, sync low reset
`timescale 1ns/1ns
`default_nettype none
module ipf_monitor #(
    parameter int DATA_W = 16
) (
    input wire logic                         core_clk,    // core clock
    input wire logic                         rst_n,       // sync reset, low
    input wire logic                         clk_en,      // clock enable
    input wire ipf_pkg::ipf_bus_req_s        bus_req,     // register request
    input wire logic [DATA_W-1:0]            rd_data,     // read data
    input wire logic [ipf_pkg::NUM_SRC-1:0]  src_pend,    // pending flags
    input wire ipf_pkg::ipf_prio_s           prio_fields, // field copy
    input wire logic                         irq_req,     // request
    input wire logic [ipf_pkg::PRIO_W-1:0]   irq_level,   // winner level
    input wire logic [ipf_pkg::SRC_ID_W-1:0] irq_src_id   // winner index
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ----------------
    // helper logic
    // ----------------
    logic [11:0] pv;
    logic [3:0]  en;
    logic [3:0]  pend_q;
    logic [8:0]  wpack;
    // flat fields, enabled sources, written gen fields
    assign pv    = prio_fields;
    assign en    = {|pv[11:9], |pv[8:6], |pv[5:3], |pv[2:0]};
    assign wpack = {bus_req.wdata[10:8], bus_req.wdata[6:4], bus_req.wdata[2:0]};
    // pending flags as the arbiter saw them
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_q <= 4'h0;
        end else if (clk_en) begin
            pend_q <= src_pend;
        end
    end

    // ----------------
    // assertions
    // ----------------
    chk_reset_values: assert property (disable iff (1'b0) !rst_n |=>
        prio_fields == {4{3'h4}} && !irq_req) else $error("fields not at reset value");
    chk_word0_read: assert property ($past(rst_n) && $past(clk_en) && $past(bus_req.rd)
        && $past(bus_req.addr) == 4'h0 |-> rd_data == {5'h0, prio_fields.pwm_gen4_prio, 1'h0,
        prio_fields.pwm_gen3_prio, 1'h0, prio_fields.pwm_gen2_prio}) else $error("first register read wrong");
    chk_word1_read: assert property ($past(rst_n) && $past(clk_en) && $past(bus_req.rd)
        && $past(bus_req.addr) == 4'h1 |-> rd_data == {1'h0, prio_fields.change_notify_prio, 12'h0})
        else $error("second register read wrong");
    chk_gen_write: assert property (clk_en && bus_req.wr && bus_req.addr == 4'h0 ##1 clk_en |=>
        prio_fields[8:0] == $past(wpack, 2)) else $error("generator fields missed a write");
    chk_cn_write: assert property (clk_en && bus_req.wr && bus_req.addr == 4'h1 ##1 clk_en |=>
        prio_fields.change_notify_prio == $past(bus_req.wdata[14:12], 2)) else $error("notify field missed a write");
    chk_win_level: assert property (irq_req |-> irq_level != 3'h0 && irq_level == pv[irq_src_id*3 +: 3])
        else $error("request level differs from winner field");
    chk_disabled_quiet: assert property ((pend_q & en) == 4'h0 |-> !irq_req)
        else $error("request without enabled pending source");
    chk_win_pending: assert property ($past(rst_n) && irq_req |-> pend_q[irq_src_id])
        else $error("winner was not pending");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench: self-checking bench for the priority field block
// assumes: ipf_pkg and rtl compiled first, monitor bound at the foot
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, e) begin n_checks++; if ((got) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e); end end
module testbench;
    logic                  core_clk;
    logic                  rst_n;
    logic                  clk_en;
    ipf_pkg::ipf_bus_req_s bus_req;
    logic [15:0]           rd_data;
    logic [3:0]            src_pend;
    ipf_pkg::ipf_prio_s    prio_fields;
    logic                  irq_req;
    logic [2:0]            irq_level;
    logic [1:0]            irq_src_id;
    logic [11:0]           fm;            // expected field values
    int                    n_errors = 0;
    int                    n_checks = 0;
    int                    seed = 50922;
    int                    cycles = 0;

    ipf_top #(.DATA_W(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
        .rd_data(rd_data), .src_pend(src_pend), .prio_fields(prio_fields), .irq_req(irq_req),
        .irq_level(irq_level), .irq_src_id(irq_src_id));

    // 250 MHz clock
    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // expected request, level and winner, lower index wins a tie
    function automatic logic [5:0] arb(input logic [3:0] p, input logic [11:0] f);
        logic [2:0] bl;
        logic [1:0] bi;
        bl = 3'h0;
        bi = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (p[i] && f[3*i +: 3] > bl) begin
                bl = f[3*i +: 3];
                bi = 2'(i);
            end
        end
        return {bl != 3'h0, bl, bi};
    endfunction

    // expected first register word
    function automatic logic [15:0] w0(input logic [11:0] f);
        return {5'h0, f[8:6], 1'h0, f[5:3], 1'h0, f[2:0]};
    endfunction

    // one strobe cycle, then settle past the answer edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        acc(1'b1, a, d);
        if (a == 4'h0) fm[8:0] = {d[10:8], d[6:4], d[2:0]};
        if (a == 4'h1) fm[11:9] = d[14:12];
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0);
        `CHK(rd_data, e)
    endtask

    // hold pending flags, let arbitration settle, compare
    // status word mirrors the arbitration result
    task automatic arb_chk(input logic [3:0] p);
        logic [5:0] r;
        @(posedge core_clk);
        src_pend <= p;
        repeat (3) @(posedge core_clk);
        #1;
        r = arb(p, fm);
        `CHK({irq_req, irq_level, irq_src_id}, r)
        rd_chk(4'h2, {6'h0, r[1:0], 1'h0, r[4:2], 3'h0, r[5]});
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------
    // hang guard
    // ----------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ----------------
    // main sequence
    // ----------------
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        bus_req = '0;
        src_pend = 4'h0;
        fm = {4{3'h4}};
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(4'h0, 16'h0444);
        rd_chk(4'h1, 16'h4000);
        `CHK(prio_fields, 12'h924)
        $display("test reset values done");
        wr_reg(4'h0, 16'hffff);
        rd_chk(4'h0, 16'h0777);
        wr_reg(4'h1, 16'hffff);
        rd_chk(4'h1, 16'h7000);
        wr_reg(4'h9, 16'h0000);
        rd_chk(4'h9, 16'h0000);
        rd_chk(4'h2, 16'h8000);
        wr_reg(4'h2, 16'h8000);
        rd_chk(4'h2, 16'h0000);
        rd_chk(4'h0, 16'h0777);
        $display("test unused bits done");
        wr_reg(4'h1, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr_reg(4'h0, {13'h0, 3'(c)});
            arb_chk(4'hf);
        end
        wr_reg(4'h0, 16'h0555);
        wr_reg(4'h1, 16'h5000);
        arb_chk(4'hf);
        arb_chk(4'he);
        $display("test codes and ties done");
        for (int k = 0; k < 40; k++) begin
            wr_reg(4'h0, 16'($random(seed)));
            wr_reg(4'h1, 16'($random(seed)));
            rd_chk(4'h0, w0(fm));
            rd_chk(4'h1, {1'h0, fm[11:9], 12'h0});
            arb_chk(4'($random(seed)));
        end
        $display("test random fields done");
        @(posedge core_clk);
        clk_en <= 1'b0;
        acc(1'b1, 4'h0, 16'h0000);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd_chk(4'h0, w0(fm));
        $display("test clock enable done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        src_pend <= 4'h0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        fm = {4{3'h4}};
        rd_chk(4'h0, 16'h0444);
        rd_chk(4'h1, 16'h4000);
        arb_chk(4'h9);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule

bind ipf_top ipf_monitor #(.DATA_W(DATA_W)) u_mon (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .src_pend(src_pend), .prio_fields(prio_fields),
    .irq_req(irq_req), .irq_level(irq_level), .irq_src_id(irq_src_id));
`default_nettype wire
